// *** gsw_gain_switch.sv ***
// gain set switch: register file, mode logic and ramp sequencer
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`include "gsw_map.svh"
`timescale 1ns/100ps
`default_nettype none
module gsw_gain_switch #(
    parameter int CYCLES_PER_MS = `GSW_CYCLES_PER_MS
) (
    input  wire logic              clock,
    input  wire logic              arst_n,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              gain_select,
    input  wire logic              position_control,
    input  wire logic              positioning_done_output,
    input  wire logic              near_output,
    input  wire logic              ref_filter_zero,
    input  wire logic              ref_pulse_active,
    input  wire logic              reference_present,
    input  wire logic              motor_stopped,
    output var  gsw_pkg::gsw_word_t speed_loop_gain,
    output var  gsw_pkg::gsw_word_t speed_integral_time,
    output var  gsw_pkg::gsw_word_t position_loop_gain,
    output var  gsw_pkg::gsw_word_t torque_filter_time,
    output var  gsw_pkg::gsw_word_t follow_model_gain,
    output var  gsw_pkg::gsw_word_t follow_model_comp,
    output var  gsw_pkg::gsw_word_t friction_comp_gain
);
    localparam int PW = $clog2(CYCLES_PER_MS + 1);

    if (CYCLES_PER_MS < 1) begin : g_chk
        $error("CYCLES_PER_MS must be at least 1");
    end

    ////////////////////////////////////////////////////////////////////
    // helper functions

    function automatic logic [4:0] reg_idx(input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        reg_idx = `GSW_IDX_NONE;
        if (a[1:0] == 2'h0) begin
            if (a == `GSW_OFS_CONFIG) begin
                reg_idx = `GSW_IDX_CONFIG;
            end else if (a == `GSW_OFS_STATUS) begin
                reg_idx = `GSW_IDX_STATUS;
            end else if (a >= `GSW_OFS_FIRST &&
                         a < `GSW_OFS_FIRST + `GSW_SET_SPAN) begin
                d = a - `GSW_OFS_FIRST;
                reg_idx = `GSW_IDX_FIRST + {2'h0, d[4:2]};
            end else if (a >= `GSW_OFS_SECOND &&
                         a < `GSW_OFS_SECOND + `GSW_SET_SPAN) begin
                d = a - `GSW_OFS_SECOND;
                reg_idx = `GSW_IDX_SECOND + {2'h0, d[4:2]};
            end else if (a >= `GSW_OFS_TIMES &&
                         a < `GSW_OFS_TIMES + `GSW_TIME_SPAN) begin
                d = a - `GSW_OFS_TIMES;
                reg_idx = `GSW_IDX_TIMES + {3'h0, d[3:2]};
            end
        end
    endfunction

    function automatic gsw_pkg::gsw_word_t rst_val(input int i);
        rst_val = `GSW_RST_TIME;
        if (i == 0) begin
            rst_val = `GSW_RST_CONFIG;
        end else if (i < 15) begin
            case ((i - 1) % `GSW_NUM_GAINS)
                0: rst_val = `GSW_RST_SPEED_GAIN;
                1: rst_val = `GSW_RST_SPEED_INTEG;
                2: rst_val = `GSW_RST_POS_GAIN;
                3: rst_val = `GSW_RST_TORQUE_FILT;
                4: rst_val = `GSW_RST_MF_GAIN;
                5: rst_val = `GSW_RST_MF_COMP;
                default: rst_val = `GSW_RST_FRICTION;
            endcase
        end
    endfunction

    function automatic logic is_mf(input int i);
        is_mf = (i == `GSW_GAIN_MF) || (i == `GSW_GAIN_MF_COMP);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic [7:0] pins_s;
    logic       gsel_s;
    logic       pos_s;
    logic       done_s;
    logic       near_s;
    logic       fzero_s;
    logic       pulse_s;
    logic       refp_s;
    logic       stop_s;

    gsw_sync #(
        .W (8)
    ) u_sync (
        .clock  (clock),
        .arst_n (arst_n),
        .d      ({gain_select, position_control, positioning_done_output,
                  near_output, ref_filter_zero, ref_pulse_active,
                  reference_present, motor_stopped}),
        .q      (pins_s)
    );

    assign {gsel_s, pos_s, done_s, near_s,
            fzero_s, pulse_s, refp_s, stop_s} = pins_s;

    ////////////////////////////////////////////////////////////////////
    // register file and axi4-lite write channel

    gsw_pkg::gsw_word_t par_q [`GSW_NUM_REGS];
    logic               aw_hold_q;
    logic [7:0]         aw_addr_q;
    logic               w_hold_q;
    logic [31:0]        w_data_q;
    logic [3:0]         w_strb_q;
    logic [4:0]         w_idx;
    logic               wr_go;

    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
    assign wr_go         = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign w_idx         = reg_idx(aw_addr_q);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            w_hold_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_go) begin
            w_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `GSW_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (w_idx == `GSW_IDX_NONE) ?
                            `GSW_RESP_SLVERR : `GSW_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // both gain sets and the timing words live here
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < `GSW_NUM_REGS; i++) begin
                par_q[i] <= rst_val(i);
            end
        end else if (wr_go && w_idx < 5'(`GSW_NUM_REGS)) begin
            if (w_strb_q[0]) begin
                par_q[w_idx][7:0] <= w_data_q[7:0];
            end
            if (w_strb_q[1]) begin
                par_q[w_idx][15:8] <= w_data_q[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mode and condition decode

    logic [3:0] mode;
    logic [3:0] cond_sel;
    logic       auto_mode;
    logic       cond_a;
    logic       fixed_second;
    logic       auto_run;

    assign mode      = par_q[`GSW_IDX_CONFIG][`GSW_MODE_LSB +: 4];
    assign cond_sel  = par_q[`GSW_IDX_CONFIG][`GSW_COND_LSB +: 4];
    assign auto_mode = (mode == `GSW_MODE_AUTO);
    assign auto_run  = auto_mode && pos_s;

    always_comb begin
        case (cond_sel)
            `GSW_COND_DONE_ON:  cond_a = done_s;
            `GSW_COND_DONE_OFF: cond_a = !done_s;
            `GSW_COND_NEAR_ON:  cond_a = near_s;
            `GSW_COND_NEAR_OFF: cond_a = !near_s;
            `GSW_COND_REF_IDLE: cond_a = fzero_s && !pulse_s;
            `GSW_COND_PULSE_ON: cond_a = pulse_s;
            default:            cond_a = 1'b0;
        endcase
    end

    // manual follows the select input; auto outside position control
    // sits on the set that the condition digit fixes
    assign fixed_second = auto_mode ? cond_sel[0] : gsel_s;

    ////////////////////////////////////////////////////////////////////
    // automatic switching sequencer

    gsw_pkg::gsw_state_t state_q;
    gsw_pkg::gsw_state_t state_d;
    logic [PW-1:0]       presc_q;
    logic [15:0]         ms_cnt_q;
    logic                ms_tick;
    logic                timing;
    logic                ramping;
    logic                to_second;
    logic                base_second;
    logic [15:0]         ramp_total;

    assign timing  = (state_q != gsw_pkg::GSW_ST_FIRST) &&
                     (state_q != gsw_pkg::GSW_ST_SECOND);
    assign ms_tick = (presc_q == PW'(CYCLES_PER_MS - 1));

    always_comb begin
        state_d = state_q;
        if (!auto_run) begin
            state_d = fixed_second ? gsw_pkg::GSW_ST_SECOND :
                                     gsw_pkg::GSW_ST_FIRST;
        end else begin
            case (state_q)
                gsw_pkg::GSW_ST_FIRST: begin
                    if (cond_a) begin
                        state_d = gsw_pkg::GSW_ST_WAIT_SECOND;
                    end
                end
                gsw_pkg::GSW_ST_WAIT_SECOND: begin
                    if (!cond_a) begin
                        state_d = gsw_pkg::GSW_ST_FIRST;
                    end else if (ms_cnt_q >=
                                 par_q[`GSW_IDX_TIMES +
                                       `GSW_T_WAIT_SECOND]) begin
                        state_d = gsw_pkg::GSW_ST_RAMP_SECOND;
                    end
                end
                gsw_pkg::GSW_ST_RAMP_SECOND: begin
                    if (ms_cnt_q >= ramp_total) begin
                        state_d = gsw_pkg::GSW_ST_SECOND;
                    end
                end
                gsw_pkg::GSW_ST_SECOND: begin
                    if (!cond_a) begin
                        state_d = gsw_pkg::GSW_ST_WAIT_FIRST;
                    end
                end
                gsw_pkg::GSW_ST_WAIT_FIRST: begin
                    if (cond_a) begin
                        state_d = gsw_pkg::GSW_ST_SECOND;
                    end else if (ms_cnt_q >=
                                 par_q[`GSW_IDX_TIMES +
                                       `GSW_T_WAIT_FIRST]) begin
                        state_d = gsw_pkg::GSW_ST_RAMP_FIRST;
                    end
                end
                gsw_pkg::GSW_ST_RAMP_FIRST: begin
                    if (ms_cnt_q >= ramp_total) begin
                        state_d = gsw_pkg::GSW_ST_FIRST;
                    end
                end
                default: state_d = gsw_pkg::GSW_ST_FIRST;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= gsw_pkg::GSW_ST_FIRST;
        end else begin
            state_q <= state_d;
        end
    end

    // millisecond prescaler and elapsed count, cleared on each step
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            presc_q  <= '0;
            ms_cnt_q <= 16'h0000;
        end else if (state_d != state_q || !timing) begin
            presc_q  <= '0;
            ms_cnt_q <= 16'h0000;
        end else if (ms_tick) begin
            presc_q <= '0;
            if (ms_cnt_q != 16'hFFFF) begin
                ms_cnt_q <= ms_cnt_q + 16'h0001;
            end
        end else begin
            presc_q <= presc_q + PW'(1);
        end
    end

    assign to_second   = (state_q == gsw_pkg::GSW_ST_RAMP_SECOND);
    assign ramping     = to_second ||
                         (state_q == gsw_pkg::GSW_ST_RAMP_FIRST);
    assign base_second = (state_q == gsw_pkg::GSW_ST_SECOND) ||
                         (state_q == gsw_pkg::GSW_ST_WAIT_FIRST);
    assign ramp_total  = to_second ?
                         par_q[`GSW_IDX_TIMES + `GSW_T_RAMP_SECOND] :
                         par_q[`GSW_IDX_TIMES + `GSW_T_RAMP_FIRST];

    ////////////////////////////////////////////////////////////////////
    // model following pair: manual only, at standstill without reference

    logic mf_second_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mf_second_q <= 1'b0;
        end else if (mode == `GSW_MODE_MANUAL &&
                     gsel_s != mf_second_q &&
                     !refp_s && stop_s) begin
            mf_second_q <= gsel_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // applied gains

    gsw_pkg::gsw_word_t gain_out [`GSW_NUM_GAINS];

    for (genvar g = 0; g < `GSW_NUM_GAINS; g++) begin : g_gain
        gsw_ramp u_ramp (
            .clock      (clock),
            .arst_n     (arst_n),
            .first_val  (par_q[`GSW_IDX_FIRST + g]),
            .second_val (par_q[`GSW_IDX_SECOND + g]),
            .at_second  (is_mf(g) ? mf_second_q : base_second),
            .ramping    (is_mf(g) ? 1'b0 : ramping),
            .to_second  (to_second),
            .elapsed_ms (ms_cnt_q),
            .total_ms   (ramp_total),
            .value_q    (gain_out[g])
        );
    end

    assign speed_loop_gain     = gain_out[0];
    assign speed_integral_time = gain_out[1];
    assign position_loop_gain  = gain_out[2];
    assign torque_filter_time  = gain_out[3];
    assign follow_model_gain   = gain_out[4];
    assign follow_model_comp   = gain_out[5];
    assign friction_comp_gain  = gain_out[6];

    ////////////////////////////////////////////////////////////////////
    // axi4-lite read channel

    logic [4:0]  r_idx;
    logic [31:0] r_word;

    assign s_axi_arready = !s_axi_rvalid;
    assign r_idx         = reg_idx(s_axi_araddr);

    always_comb begin
        r_word = 32'h00000000;
        if (r_idx < 5'(`GSW_NUM_REGS)) begin
            r_word = {16'h0000, par_q[r_idx]};
        end else if (r_idx == `GSW_IDX_STATUS) begin
            r_word = {18'h00000, state_q, 5'h00,
                      ramping, mf_second_q, base_second};
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `GSW_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= r_word;
            s_axi_rresp  <= (r_idx == `GSW_IDX_NONE) ?
                            `GSW_RESP_SLVERR : `GSW_RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** gsw_map.svh ***
// register offsets, field positions, reset values and timing counts
// What this block does
// - config mode digit: 0 manual, 2 auto
// - hold complete first and second gain sets
// - manual: select off first, on second
// - follow model pair switches in manual only
// - follow pair needs request, no reference, stopped
// - automatic switching only under position control
// - condition true: wait1 then ramp1 to second
// - condition false: wait2 then ramp2 to first
// - condition digit 0..3: done/near on or off
// - condition 4: filter zero and no pulses, 5: pulses active
// - outside position control: fixed set by condition
// - after wait, ramp gains linearly over time
`ifndef GSW_MAP_SVH
`define GSW_MAP_SVH
`define GSW_OFS_CONFIG 8'h00
`define GSW_OFS_STATUS 8'h04
`define GSW_OFS_FIRST 8'h40
`define GSW_OFS_SECOND 8'h60
`define GSW_OFS_TIMES 8'h80
`define GSW_SET_SPAN 8'h1C
`define GSW_TIME_SPAN 8'h10
`define GSW_IDX_CONFIG 5'h00
`define GSW_IDX_FIRST 5'h01
`define GSW_IDX_SECOND 5'h08
`define GSW_IDX_TIMES 5'h0F
`define GSW_IDX_STATUS 5'h1E
`define GSW_IDX_NONE 5'h1F
`define GSW_NUM_REGS 19
`define GSW_NUM_GAINS 7
`define GSW_GAIN_MF 4
`define GSW_GAIN_MF_COMP 5
`define GSW_T_WAIT_SECOND 0
`define GSW_T_WAIT_FIRST 1
`define GSW_T_RAMP_SECOND 2
`define GSW_T_RAMP_FIRST 3
`define GSW_MODE_LSB 0
`define GSW_COND_LSB 4
`define GSW_MODE_MANUAL 4'h0
`define GSW_MODE_AUTO 4'h2
`define GSW_COND_DONE_ON 4'h0
`define GSW_COND_DONE_OFF 4'h1
`define GSW_COND_NEAR_ON 4'h2
`define GSW_COND_NEAR_OFF 4'h3
`define GSW_COND_REF_IDLE 4'h4
`define GSW_COND_PULSE_ON 4'h5
`define GSW_RST_CONFIG 16'h0000
`define GSW_RST_SPEED_GAIN 16'h0190
`define GSW_RST_SPEED_INTEG 16'h07D0
`define GSW_RST_POS_GAIN 16'h0190
`define GSW_RST_TORQUE_FILT 16'h0064
`define GSW_RST_MF_GAIN 16'h01F4
`define GSW_RST_MF_COMP 16'h03E8
`define GSW_RST_FRICTION 16'h0064
`define GSW_RST_TIME 16'h0000
`define GSW_TIME_UNIT_NS 1000000
`define GSW_CLK_PERIOD_NS 10
`define GSW_CYCLES_PER_MS (`GSW_TIME_UNIT_NS / `GSW_CLK_PERIOD_NS)
`define GSW_RESP_OKAY 2'h0
`define GSW_RESP_SLVERR 2'h2
`endif

// *** gsw_pkg.sv ***
// types shared by the gain switch files
package gsw_pkg;
    typedef logic [15:0] gsw_word_t;
    typedef enum logic [5:0] {
        GSW_ST_FIRST       = 6'h01,
        GSW_ST_WAIT_SECOND = 6'h02,
        GSW_ST_RAMP_SECOND = 6'h04,
        GSW_ST_SECOND      = 6'h08,
        GSW_ST_WAIT_FIRST  = 6'h10,
        GSW_ST_RAMP_FIRST  = 6'h20
    } gsw_state_t;
endpackage

// *** gsw_sync.sv ***
// two flip-flop synchroniser for a group of levels
`timescale 1ns/100ps
`default_nettype none
module gsw_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// *** gsw_ramp.sv ***
// one applied gain: set select or linear ramp between the sets
`timescale 1ns/100ps
`default_nettype none
module gsw_ramp (
    input  wire logic              clock,
    input  wire logic              arst_n,
    input  wire gsw_pkg::gsw_word_t first_val,
    input  wire gsw_pkg::gsw_word_t second_val,
    input  wire logic              at_second,
    input  wire logic              ramping,
    input  wire logic              to_second,
    input  wire logic [15:0]       elapsed_ms,
    input  wire logic [15:0]       total_ms,
    output var  gsw_pkg::gsw_word_t value_q
);
    gsw_pkg::gsw_word_t from_v;
    gsw_pkg::gsw_word_t to_v;
    gsw_pkg::gsw_word_t value_d;
    logic signed [16:0] delta;
    logic signed [33:0] prod;
    logic signed [33:0] step;

    always_comb begin
        from_v  = to_second ? first_val : second_val;
        to_v    = to_second ? second_val : first_val;
        delta   = $signed({1'b0, to_v}) - $signed({1'b0, from_v});
        prod    = delta * $signed({1'b0, elapsed_ms});
        step    = '0;
        value_d = at_second ? second_val : first_val;
        if (ramping) begin
            if (total_ms != 16'h0000) begin
                step    = prod / $signed({18'h00000, total_ms});
                value_d = from_v + step[15:0];
            end else begin
                value_d = to_v;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            value_q <= 16'h0000;
        end else begin
            value_q <= value_d;
        end
    end
endmodule
`default_nettype wire

// *** gsw_host.sv ***
// host controller model: gain select and drive status levels
`timescale 1ns/100ps
`default_nettype none
module gsw_host (
    output var logic [7:0] lvl
);
    // bit order: stopped, ref present, pulse, filter zero, near, done, pos, sel
    initial lvl = 8'h00;
    // called right after a clock edge, so levels move off the sampling edge
    task automatic drive(input logic [7:0] v);
        lvl <= v;
    endtask
endmodule
`default_nettype wire

// *** gsw_sva.sv ***
// port checker for the gain set switch
`timescale 1ns/100ps
`default_nettype none
module gsw_sva (
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        reference_present,
    input wire logic [15:0] follow_model_gain
);
    wire logic wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////
    property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_rd_ref; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_rd_ref: assert property (p_rd_ref) else $error("read taken while busy");
    property p_rd_busy; s_axi_arvalid && s_axi_arready |=> !s_axi_arready;
    endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("second read open");
    property p_wr_early; wr_go |=> !s_axi_bvalid; endproperty
    a_wr_early: assert property (p_wr_early) else $error("write answer early");
    property p_wr_ans; wr_go |-> ##2 s_axi_bvalid; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
    property p_wr_ref; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_wr_ref: assert property (p_wr_ref) else $error("write taken while busy");
    property p_wr_hold; wr_go |=> !s_axi_awready && !s_axi_wready;
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write not held");
    property p_mf_hold; (reference_present && !s_axi_bvalid) [*6] |=>
        $stable(follow_model_gain); endproperty
    a_mf_hold: assert property (p_mf_hold)
        else $error("follow gain moved with reference");
endmodule
////////////////////////////////////////
bind gsw_gain_switch gsw_sva u_sva (.clock(clock), .arst_n(arst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .reference_present(reference_present),
    .follow_model_gain(follow_model_gain));
`default_nettype wire

// *** gsw_gain_switch_tb.sv ***
// self-checking bench for the gain set switch
`timescale 1ns/100ps
`default_nettype none
module gsw_gain_switch_tb;
    logic        clock = 1'b0, arst_n = 1'b0;
    logic        awv = 1'b0, wv = 1'b0, arv = 1'b0, bre = 1'b0, rre = 1'b0;
    logic        awr, wr, bv, arr, rv;
    logic [1:0]  br, rr;
    logic [7:0]  aa = 8'h00, hl;
    logic [3:0]  ws = 4'h3;
    logic [31:0] wd = 32'h0, rd;
    logic [15:0] spd, mfg, plg, mfc;
    int          miscompares = 0, compares = 0, cycles = 0;
    gsw_host host (.lvl(hl));
    gsw_gain_switch #(.CYCLES_PER_MS(4)) uut (.clock(clock), .arst_n(arst_n),
        .s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bre), .s_axi_araddr(aa), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rre), .gain_select(hl[0]),
        .position_control(hl[1]), .positioning_done_output(hl[2]),
        .near_output(hl[3]), .ref_filter_zero(hl[4]),
        .ref_pulse_active(hl[5]), .reference_present(hl[6]),
        .motor_stopped(hl[7]), .speed_loop_gain(spd),
        .speed_integral_time(), .position_loop_gain(plg),
        .torque_filter_time(), .follow_model_gain(mfg),
        .follow_model_comp(mfc), .friction_comp_gain());
    ////////////////////////////////////////
    task automatic check(input string nm, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic end_of_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one register access, read or write, then response compare
    task automatic axi(input logic is_rd, input logic [7:0] a,
                       input logic [15:0] d, input logic [1:0] er);
        @(posedge clock);
        aa <= a;
        wd <= {16'h0000, d};
        {awv, wv, bre} <= {3{!is_rd}};
        {arv, rre} <= {2{is_rd}};
        do begin
            @(posedge clock);
            if (awr && awv) awv <= 1'b0;
            if (wr && wv) wv <= 1'b0;
            if (arr && arv) arv <= 1'b0;
        end while (!(is_rd ? rv : bv));
        {bre, rre} <= 2'b00;
        check("resp", {14'h0000, (is_rd ? rr : br)}, {14'h0000, er});
        if (is_rd) check("rdata", rd[15:0], d);
    endtask
    ////////////////////////////////////////
    task automatic t_regs();
        logic [15:0] dv [7];
        dv = '{16'h0190, 16'h07D0, 16'h0190, 16'h0064, 16'h01F4, 16'h03E8,
               16'h0064};
        axi(1'b1, 8'h00, 16'h0000, 2'h0);
        for (int i = 0; i < 14; i++)
            axi(1'b1, 8'h40 + 8'(4 * i + 4 * (i / 7)), dv[i % 7], 2'h0);
        axi(1'b1, 8'hFC, 16'h0000, 2'h2);
        ws <= 4'h1;
        axi(1'b0, 8'h44, 16'hFFAA, 2'h0);
        ws <= 4'h3;
        axi(1'b1, 8'h44, 16'h07AA, 2'h0);
        $display("register test done");
    endtask
    task automatic t_manual();
        axi(1'b0, 8'h60, 16'h0123, 2'h0);
        axi(1'b0, 8'h70, 16'h0456, 2'h0);
        axi(1'b0, 8'h68, 16'h0200, 2'h0);
        axi(1'b0, 8'h74, 16'h0789, 2'h0);
        host.drive(8'h41);
        tick(8);
        check("spd", spd, 16'h0123);
        check("plg", plg, 16'h0200);
        check("mfg", mfg, 16'h01F4);
        check("mfc", mfc, 16'h03E8);
        host.drive(8'h81);
        tick(8);
        check("mfg", mfg, 16'h0456);
        check("mfc", mfc, 16'h0789);
        host.drive(8'h80);
        tick(8);
        check("spd", spd, 16'h0190);
        check("plg", plg, 16'h0190);
        check("mfg", mfg, 16'h01F4);
        $display("manual test done");
    endtask
    task automatic t_ramp();
        axi(1'b0, 8'h80, 16'h0002, 2'h0);
        axi(1'b0, 8'h88, 16'h0004, 2'h0);
        axi(1'b0, 8'h00, 16'h0002, 2'h0);
        host.drive(8'h02);
        tick(8);
        host.drive(8'h06);
        tick(9);
        check("wait", spd, 16'h0190);
        tick(14);
        check("mid", 16'(spd < 16'h0190 && spd > 16'h0123), 16'h0001);
        tick(30);
        check("spd", spd, 16'h0123);
        check("mfg", mfg, 16'h01F4);
        host.drive(8'h02);
        tick(10);
        check("spd", spd, 16'h0190);
        $display("ramp test done");
    endtask
    task automatic t_cond();
        logic [7:0] tv [6], fv [6];
        tv = '{8'h06, 8'h02, 8'h0A, 8'h02, 8'h12, 8'h22};
        fv = '{8'h02, 8'h06, 8'h02, 8'h0A, 8'h02, 8'h02};
        axi(1'b0, 8'h80, 16'h0000, 2'h0);
        axi(1'b0, 8'h88, 16'h0000, 2'h0);
        for (int c = 0; c < 6; c++) begin
            axi(1'b0, 8'h00, {8'h00, 4'(c), 4'h2}, 2'h0);
            host.drive(fv[c]);
            tick(10);
            check("cond_f", spd, 16'h0190);
            host.drive(tv[c]);
            tick(10);
            check("cond_t", spd, 16'h0123);
            host.drive((c % 2 == 0 ? tv[c] : fv[c]) & 8'hFD);
            tick(10);
            check("fixed", spd, c % 2 == 0 ? 16'h0190 : 16'h0123);
        end
        $display("condition test done");
    endtask
    ////////////////////////////////////////
    initial forever #5 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            end_of_test();
        end
    end
    initial begin
        tick(16);
        arst_n <= 1'b1;
        t_regs();
        t_manual();
        t_ramp();
        t_cond();
        end_of_test();
    end
endmodule
`default_nettype wire
